// File: verilog/fb_pmem_pkg.sv
// constants for the feedback, output power and phase memory limit registers
package fb_pmem_pkg;
   // register offsets on the host port
   localparam logic [6:0] FB_CTRL_OFFSET    = 7'h45;
   localparam logic [6:0] OUT_POWER_OFFSET  = 7'h46;
   localparam logic [6:0] PMEM_IN0_OFFSET   = 7'h47;
   localparam logic [6:0] PMEM_IN1_OFFSET   = 7'h48;
   localparam logic [6:0] PMEM_IN2_OFFSET   = 7'h49;
   // reset values
   localparam logic [7:0] FB_CTRL_RESET     = 8'h00;
   localparam logic [7:0] OUT_POWER_RESET   = 8'hff;
   localparam logic [7:0] PMEM_RESET        = 8'h0a;
   // feedback control field positions
   localparam int         LOOP_CHOICE_BIT   = 0;
   localparam int         SOURCE_LSB        = 2;
   localparam int         SOURCE_MSB        = 3;
   localparam int         GLOBAL_ON_BIT     = 7;
   // writable bits of feedback control; reserved bits stay at reset
   localparam logic [7:0] FB_CTRL_RW_MASK   = 8'h8d;
   // per-loop mode register feedback enable position
   localparam int         LOOP_FB_ON_BIT    = 5;
endpackage

// File: verilog/fb_pmem_regs.sv
// external feedback, output power and phase memory limit register bank

module fb_pmem_regs (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   // register port
   input  wire logic       i_wr_en,
   input  wire logic       i_rd_en,
   input  wire logic [6:0] i_addr,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata,
   output logic            o_rd_hit,
   // per-loop mode register bit 5, held in the neighbouring register
   input  wire logic       i_loop0_mode_fb,
   input  wire logic       i_loop1_mode_fb,
   // feedback phase path
   output logic            o_feedback_loop_choice,
   output logic      [1:0] o_feedback_source_choice,
   output logic            o_feedback_global_on,
   output logic            o_loop0_compensate,
   output logic            o_loop1_compensate,
   // output drivers and phase memory
   output logic      [7:0] o_diff_out_low_power,
   output logic      [7:0] o_input0_phase_memory_code,
   output logic      [7:0] o_input1_phase_memory_code,
   output logic      [7:0] o_input2_phase_memory_code
);

   logic [7:0] fb_ctrl_r,   fb_ctrl_nxt;
   logic [7:0] out_pwr_r,   out_pwr_nxt;
   logic [7:0] pmem0_r,     pmem0_nxt;
   logic [7:0] pmem1_r,     pmem1_nxt;
   logic [7:0] pmem2_r,     pmem2_nxt;
   logic [7:0] rdata_r,     rdata_nxt;
   logic       rd_hit_r,    rd_hit_nxt;
   logic       comp0_r,     comp0_nxt;
   logic       comp1_r,     comp1_nxt;

   function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
      hit = (a == off);
   endfunction

   always_comb begin
      fb_ctrl_nxt = fb_ctrl_r;
      out_pwr_nxt = out_pwr_r;
      pmem0_nxt   = pmem0_r;
      pmem1_nxt   = pmem1_r;
      pmem2_nxt   = pmem2_r;
      if (i_wr_en) begin
         if (hit(i_addr, fb_pmem_pkg::FB_CTRL_OFFSET)) begin
            // reserved bits never take the written value
            fb_ctrl_nxt = (i_wdata & fb_pmem_pkg::FB_CTRL_RW_MASK) |
                          (fb_pmem_pkg::FB_CTRL_RESET &
                           ~fb_pmem_pkg::FB_CTRL_RW_MASK);
         end
         if (hit(i_addr, fb_pmem_pkg::OUT_POWER_OFFSET)) begin
            out_pwr_nxt = i_wdata;
         end
         if (hit(i_addr, fb_pmem_pkg::PMEM_IN0_OFFSET)) begin
            pmem0_nxt = i_wdata;
         end
         if (hit(i_addr, fb_pmem_pkg::PMEM_IN1_OFFSET)) begin
            pmem1_nxt = i_wdata;
         end
         if (hit(i_addr, fb_pmem_pkg::PMEM_IN2_OFFSET)) begin
            pmem2_nxt = i_wdata;
         end
      end
   end

   // read path, one cycle latency; unmapped addresses read zero
   always_comb begin
      rdata_nxt  = 8'h00;
      rd_hit_nxt = 1'b0;
      if (i_rd_en) begin
         rd_hit_nxt = 1'b1;
         case (i_addr)
            fb_pmem_pkg::FB_CTRL_OFFSET:   rdata_nxt = fb_ctrl_r;
            fb_pmem_pkg::OUT_POWER_OFFSET: rdata_nxt = out_pwr_r;
            fb_pmem_pkg::PMEM_IN0_OFFSET:  rdata_nxt = pmem0_r;
            fb_pmem_pkg::PMEM_IN1_OFFSET:  rdata_nxt = pmem1_r;
            fb_pmem_pkg::PMEM_IN2_OFFSET:  rdata_nxt = pmem2_r;
            default:                       rd_hit_nxt = 1'b0;
         endcase
      end
   end

   // compensation needs the global enable and the loop's own enable;
   // loop choice only decides who measures the phase, not who uses it
   always_comb begin
      comp0_nxt = fb_ctrl_r[fb_pmem_pkg::GLOBAL_ON_BIT] &
                  i_loop0_mode_fb;
      comp1_nxt = fb_ctrl_r[fb_pmem_pkg::GLOBAL_ON_BIT] &
                  i_loop1_mode_fb;
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fb_ctrl_r <= fb_pmem_pkg::FB_CTRL_RESET;
         out_pwr_r <= fb_pmem_pkg::OUT_POWER_RESET;
         pmem0_r   <= fb_pmem_pkg::PMEM_RESET;
         pmem1_r   <= fb_pmem_pkg::PMEM_RESET;
         pmem2_r   <= fb_pmem_pkg::PMEM_RESET;
         rdata_r   <= 8'h00;
         rd_hit_r  <= 1'b0;
         comp0_r   <= 1'b0;
         comp1_r   <= 1'b0;
      end else begin
         fb_ctrl_r <= fb_ctrl_nxt;
         out_pwr_r <= out_pwr_nxt;
         pmem0_r   <= pmem0_nxt;
         pmem1_r   <= pmem1_nxt;
         pmem2_r   <= pmem2_nxt;
         rdata_r   <= rdata_nxt;
         rd_hit_r  <= rd_hit_nxt;
         comp0_r   <= comp0_nxt;
         comp1_r   <= comp1_nxt;
      end
   end

   assign o_rdata                    = rdata_r;
   assign o_rd_hit                   = rd_hit_r;
   assign o_feedback_loop_choice     =
      fb_ctrl_r[fb_pmem_pkg::LOOP_CHOICE_BIT];
   assign o_feedback_source_choice   =
      fb_ctrl_r[fb_pmem_pkg::SOURCE_MSB:fb_pmem_pkg::SOURCE_LSB];
   assign o_feedback_global_on       =
      fb_ctrl_r[fb_pmem_pkg::GLOBAL_ON_BIT];
   assign o_loop0_compensate         = comp0_r;
   assign o_loop1_compensate         = comp1_r;
   assign o_diff_out_low_power       = out_pwr_r;
   assign o_input0_phase_memory_code = pmem0_r;
   assign o_input1_phase_memory_code = pmem1_r;
   assign o_input2_phase_memory_code = pmem2_r;

   // checks
   property p_ctrl_write;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_wr_en && i_addr == fb_pmem_pkg::FB_CTRL_OFFSET) |=>
      (o_feedback_loop_choice == $past(i_wdata[0]) &&
       o_feedback_source_choice == $past(i_wdata[3:2]) &&
       o_feedback_global_on == $past(i_wdata[7]));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("feedback control fields not updated by write");

   property p_comp;
      @(posedge i_clk) disable iff (!i_rst_b)
      ##1 o_loop1_compensate ==
      ($past(o_feedback_global_on) && $past(i_loop1_mode_fb));
   endproperty
   a_comp: assert property (p_comp)
      else $error("loop one compensation does not follow its enables");

   property p_comp0;
      @(posedge i_clk) disable iff (!i_rst_b)
      ##1 o_loop0_compensate ==
      ($past(o_feedback_global_on) && $past(i_loop0_mode_fb));
   endproperty
   a_comp0: assert property (p_comp0)
      else $error("loop zero compensation does not follow its enables");

   property p_reserved;
      @(posedge i_clk) disable iff (!i_rst_b)
      ##1 (fb_ctrl_r[1] == 1'b0 && fb_ctrl_r[6:4] == 3'h0);
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved feedback control bits changed");

   // seen from the port, not the flops, so a leaky read mux shows up
   property p_ctrl_read;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_rd_en && i_addr == fb_pmem_pkg::FB_CTRL_OFFSET) |=>
      (o_rd_hit && o_rdata[1] == 1'b0 && o_rdata[6:4] == 3'h0);
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("reserved feedback control bits read back nonzero");

   property p_pwr_hold;
      @(posedge i_clk) disable iff (!i_rst_b)
      !(i_wr_en && i_addr == fb_pmem_pkg::OUT_POWER_OFFSET) |=>
      $stable(o_diff_out_low_power);
   endproperty
   a_pwr_hold: assert property (p_pwr_hold)
      else $error("output power changed without a write");

   property p_pmem_write;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_wr_en && i_addr == fb_pmem_pkg::PMEM_IN2_OFFSET) |=>
      o_input2_phase_memory_code == $past(i_wdata);
   endproperty
   a_pmem_write: assert property (p_pmem_write)
      else $error("input two phase memory code not written");

   property p_code_hold;
      @(posedge i_clk) disable iff (!i_rst_b)
      !i_wr_en |=> ($stable(o_input0_phase_memory_code) &&
                    $stable(o_input1_phase_memory_code) &&
                    $stable(o_input2_phase_memory_code));
   endproperty
   a_code_hold: assert property (p_code_hold)
      else $error("phase memory code changed without a write");

   property p_read_back;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_rd_en && !i_wr_en && i_addr == fb_pmem_pkg::PMEM_IN0_OFFSET) |=>
      (o_rd_hit && o_rdata == o_input0_phase_memory_code);
   endproperty
   a_read_back: assert property (p_read_back)
      else $error("phase memory read returns wrong data");

   property p_comp_off;
      @(posedge i_clk) disable iff (!i_rst_b)
      !o_feedback_global_on [*2] |-> !o_loop0_compensate;
   endproperty
   a_comp_off: assert property (p_comp_off)
      else $error("loop zero compensated with feedback disabled");

   property p_unmapped;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_rd_en && i_addr == 7'h4a) |=> (!o_rd_hit && o_rdata == 8'h00);
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read did not return zero");

endmodule

// File: sim/host_model.sv
// host register port driver standing in for control software
module host_model (
   // clock and answers from the bank
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_rd_hit,
   // request lines
   output logic            o_wr_en,
   output logic            o_rd_en,
   output logic      [6:0] o_addr,
   output logic      [7:0] o_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // feedback source kept frequency locked by the system
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr  = 7'h00;
      o_wdata = 8'h00;
   end
   // released lines show the inverse so stale values never match
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1 {o_wr_en, o_addr, o_wdata} = {1'b1, a, d};
      @(posedge i_clk);
      #1 {o_wr_en, o_addr, o_wdata} = {1'b0, ~a, ~d};
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d,
                     output logic h);
      @(posedge i_clk);
      #1 {o_rd_en, o_addr} = {1'b1, a};
      @(posedge i_clk);
      #1 {o_rd_en, o_addr} = {1'b0, ~a};
      d = i_rdata;
      h = i_rd_hit;
   endtask
endmodule

// File: sim/tb_top.sv
// self-checking bench for the feedback and phase memory bank
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, rst_b, m0, m1, wr, rd, hit, lc, gon, c0, c1, h;
   logic [6:0] addr;
   logic [7:0] wd, rdat, d, q;
   logic [1:0] src;
   logic [7:0] outs [4];
   int         err_count, checked;
   initial clk = 1'b0;
   always #4 clk = ~clk;
   fb_pmem_regs u_fb_pmem_regs (.i_clk(clk), .i_rst_b(rst_b),
      .i_wr_en(wr), .i_rd_en(rd), .i_addr(addr), .i_wdata(wd),
      .o_rdata(rdat), .o_rd_hit(hit), .i_loop0_mode_fb(m0),
      .i_loop1_mode_fb(m1), .o_feedback_loop_choice(lc),
      .o_feedback_source_choice(src), .o_feedback_global_on(gon),
      .o_loop0_compensate(c0), .o_loop1_compensate(c1),
      .o_diff_out_low_power(outs[0]),
      .o_input0_phase_memory_code(outs[1]),
      .o_input1_phase_memory_code(outs[2]),
      .o_input2_phase_memory_code(outs[3]));
   host_model u_host_model (.i_clk(clk), .i_rdata(rdat),
      .i_rd_hit(hit), .o_wr_en(wr), .o_rd_en(rd), .o_addr(addr),
      .o_wdata(wd));
   // host side limit coding, limit given in seconds; +0.5 rounds
   function automatic logic [7:0] code_of(input real lim);
      code_of = 8'($rtoi(32.0 * $log10(lim * 1.0e5) + 0.5));
   endfunction
   // recommended limits for fast, 8 kHz, 1 kHz and 1 Hz inputs
   function automatic logic [7:0] rec(input int i);
      case (i)
         0: rec = code_of(10.0e-6);
         1: rec = code_of(100.0e-6);
         2: rec = code_of(1.0e-3);
         default: rec = code_of(0.93);
      endcase
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [6:0] a, input logic [7:0] e,
                       input logic eh);
      u_host_model.rd(a, d, h);
      chk(d, e);
      chk({7'h00, h}, {7'h00, eh});
   endtask
   task automatic stop_test();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // the tests need about 155 cycles; some thirteen times that means a hang
   initial begin
      repeat (2000) @(posedge clk);
      err_count++;
      stop_test();
   end
   initial begin
      {rst_b, m0, m1} = 3'b000;
      q = 8'($urandom(32'h3f9d));
      repeat (8) @(posedge clk);
      #1 rst_b = 1'b1;
      rchk(7'h45, 8'h00, 1'b1);
      rchk(7'h46, 8'hff, 1'b1);
      for (int i = 0; i < 3; i++) rchk(7'(7'h47 + i), 8'h0a, 1'b1);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         q = {~i[0], 7'($urandom())};
         q[3:0] = i[3:0];
         {m0, m1} = 2'($urandom());
         u_host_model.wr(7'h45, q);
         @(posedge clk);
         #1 chk({7'h00, lc}, {7'h00, q[0]});
         chk({6'h00, src}, {6'h00, q[3:2]});
         chk({7'h00, gon}, {7'h00, q[7]});
         chk({6'h00, c1, c0}, {6'h00, q[7] & m1, q[7] & m0});
         rchk(7'h45, q & 8'h8d, 1'b1);
      end
      $display("test feedback control done");
      for (int i = 0; i < 12; i++) begin
         q = (i < 4) ? rec(i) : 8'($urandom());
         u_host_model.wr(7'(7'h46 + i % 4), q);
         chk(outs[i % 4], q);
         rchk(7'(7'h46 + i % 4), q, 1'b1);
      end
      rchk(7'h50, 8'h00, 1'b0);
      rchk(7'h4a, 8'h00, 1'b0);
      $display("test limits and power done");
      rst_b = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_b = 1'b1;
      chk(outs[0], 8'hff);
      chk(outs[3], 8'h0a);
      chk({7'h00, gon}, 8'h00);
      rchk(7'h46, 8'hff, 1'b1);
      $display("test second reset done");
      stop_test();
   end
endmodule
